//--- rtl/l2edc_ctrl.v
// Strobed register access and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
`include "l2edc_defs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// - bit 6 clears dma flag and address
// - bit 5 clears program flag and address
// - bit 4 clears data flag and address
// - bits 3/2/0 pause, disable, enable
// - several clear bits act together
// - several state bits act as disable
// - address capture holds address bits 31-5
// - bits 4-3 hold way, zero for ram
// - bit 0 marks ram; bits 2-1 zero
// - clear page bit suppresses all checking
// - enabled page checked only when enabled
// - disabled page: no parity, exception, count
// - two 8-bit error counters
// - counters count while capture is pending
// - corrected and uncorrectable exception outputs
// - one exception outstanding, capture held
// - uncorrectable overrides pending correctable capture
// - same cycle: uncorrectable, then data side
// - emulation writes make parity, narrow invalid
// - emulation reads bypass detection entirely
// - single-bit errors leave correction information, except from data level-one
// - status state and source bits
// - status type code and bit position
module l2edc_ctrl
(
  input wire ref_clk_in, // memory controller clock
  input wire rst_n_in, // async reset, active low
  // register port
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  output reg [31:0] reg_rdata_out,
  // data side port error report
  input wire dside_err_in, // error detected this cycle
  input wire dside_uncorr_in, // error not correctable
  input wire dside_emu_in, // access is an emulation read
  input wire dside_l1_in, // access came from data level-one
  input wire dside_dma_in, // access is a dma read
  input wire [31:0] dside_addr_in,
  input wire [1:0] dside_way_in,
  input wire dside_ram_in, // 1 = ram section, 0 = cache
  input wire [1:0] dside_type_in,
  input wire [7:0] dside_pos_in,
  // program side port error report
  input wire pside_err_in,
  input wire pside_uncorr_in,
  input wire pside_emu_in,
  input wire pside_dma_in,
  input wire [31:0] pside_addr_in,
  input wire [1:0] pside_way_in,
  input wire pside_ram_in,
  input wire [1:0] pside_type_in,
  input wire [7:0] pside_pos_in,
  // write path qualification for parity generation
  input wire wr_req_in, // memory write this cycle
  input wire [31:0] wr_addr_in,
  input wire wr_full_in, // write covers whole 256-bit word
  output reg par_gen_out, // store computed parity
  output reg par_valid_out, // parity valid bit to store
  // exceptions to the interrupt selector
  output reg corrected_error_exception_out,
  output reg uncorrectable_error_exception_out
);

////////////////////////////////////////////////////////////////////////////////
// state and registers
reg [1:0] state_ff; // logic state: disabled, enabled, paused
reg [1:0] nxt_state;
reg [31:0] pen0_ff; // page check bits, region 0
reg [31:0] pen1_ff; // page check bits, region 1
reg [7:0] corr_cnt_ff; // correctable error count
reg [7:0] uncorr_cnt_ff; // uncorrectable error count
reg dma_flag_ff; // dma_side_error_flag
reg prog_flag_ff; // program_side_error_flag
reg data_flag_ff; // data_side_error_flag
reg pend_uncorr_ff; // captured error is uncorrectable
reg [1:0] type_ff; // error_type_code
reg [7:0] pos_ff; // failing_bit_position
reg [26:0] cap_addr_ff; // captured address bits 31-5
reg [1:0] cap_way_ff; // failing_cache_way
reg cap_ram_ff; // ram section flag
reg [31:0] nxt_rdata;

////////////////////////////////////////////////////////////////////////////////
// page lookup: 64 pages, address bits pick the page
// limitation: page size fixed by address bits 20-15; change here if
// the memory is mapped differently
function page_on;
  input [31:0] addr;
  input [31:0] p0;
  input [31:0] p1;
  reg [5:0] idx;
  begin
    idx = addr[20:15];
    page_on = idx[5] ? p1[idx[4:0]] : p0[idx[4:0]];
  end
endfunction

// qualified errors: page gate and emulation bypass
wire checking = (state_ff == `L2EDC_STATE_EN);
wire d_page = page_on(dside_addr_in, pen0_ff, pen1_ff);
wire p_page = page_on(pside_addr_in, pen0_ff, pen1_ff);
wire d_err = dside_err_in & checking & d_page & ~dside_emu_in;
wire p_err = pside_err_in & checking & p_page & ~pside_emu_in;
wire d_unc = d_err & dside_uncorr_in;
wire p_unc = p_err & pside_uncorr_in;
wire d_cor = d_err & ~dside_uncorr_in;
wire p_cor = p_err & ~pside_uncorr_in;

////////////////////////////////////////////////////////////////////////////////
// arbitration: uncorrectable first, data side over program side
reg sel_valid; // an error wins this cycle
reg sel_unc;
reg sel_data; // winner is data side
always @*
begin
  sel_valid = 1'b0;
  sel_unc = 1'b0;
  sel_data = 1'b0;
  if (d_unc)
  begin
    sel_valid = 1'b1;
    sel_unc = 1'b1;
    sel_data = 1'b1;
  end
  else if (p_unc)
  begin
    sel_valid = 1'b1;
    sel_unc = 1'b1;
  end
  else if (d_cor)
  begin
    sel_valid = 1'b1;
    sel_data = 1'b1;
  end
  else if (p_cor)
  begin
    sel_valid = 1'b1;
  end
end

// command decode
wire cmd_wr = reg_wr_in & (reg_addr_in == `L2EDC_OFS_COMMAND);
wire clr_dma = cmd_wr & reg_wdata_in[`L2EDC_CMD_DMA_CLR];
wire clr_prog = cmd_wr & reg_wdata_in[`L2EDC_CMD_PROG_CLR];
wire clr_data = cmd_wr & reg_wdata_in[`L2EDC_CMD_DATA_CLR];
wire any_clr = clr_dma | clr_prog | clr_data;
wire pending = dma_flag_ff | prog_flag_ff | data_flag_ff;
// capture when nothing pending, or uncorrectable over correctable
wire capture = sel_valid & (~pending | (sel_unc & ~pend_uncorr_ff));
// flags left standing after this cycle's clears
wire dma_left = dma_flag_ff & ~clr_dma;
wire prog_left = prog_flag_ff & ~clr_prog;
wire data_left = data_flag_ff & ~clr_data;

////////////////////////////////////////////////////////////////////////////////
// state machine for the global logic state
always @*
begin
  nxt_state = state_ff;
  if (cmd_wr)
  begin
    case ({reg_wdata_in[`L2EDC_CMD_PAUSE], reg_wdata_in[`L2EDC_CMD_DIS], reg_wdata_in[`L2EDC_CMD_EN]})
      3'b000: nxt_state = state_ff; // no state change
      3'b100: nxt_state = `L2EDC_STATE_PAUSE;
      3'b010: nxt_state = `L2EDC_STATE_DIS;
      3'b001: nxt_state = `L2EDC_STATE_EN;
      default: nxt_state = `L2EDC_STATE_DIS;
    endcase
  end
end

always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
    state_ff <= `L2EDC_STATE_EN; // status resets with enable set
  else
    state_ff <= nxt_state;
end

////////////////////////////////////////////////////////////////////////////////
// page enable registers
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    pen0_ff <= `L2EDC_PEN_RESET;
    pen1_ff <= `L2EDC_PEN_RESET;
  end
  else
  begin
    if (reg_wr_in && reg_addr_in == `L2EDC_OFS_PEN0)
      pen0_ff <= reg_wdata_in;
    if (reg_wr_in && reg_addr_in == `L2EDC_OFS_PEN1)
      pen1_ff <= reg_wdata_in;
  end
end

////////////////////////////////////////////////////////////////////////////////
// event counters: every qualified error counts, pending or not
// wrap at 255 back to zero; no saturation requested
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    corr_cnt_ff <= `L2EDC_CNT_RESET;
    uncorr_cnt_ff <= `L2EDC_CNT_RESET;
  end
  else
  begin
    corr_cnt_ff <= corr_cnt_ff + {7'h00, d_cor} + {7'h00, p_cor};
    uncorr_cnt_ff <= uncorr_cnt_ff + {7'h00, d_unc} + {7'h00, p_unc};
  end
end

////////////////////////////////////////////////////////////////////////////////
// error flags and capture; a new capture beats a same-cycle clear
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    dma_flag_ff <= 1'b0;
    prog_flag_ff <= 1'b0;
    data_flag_ff <= 1'b0;
    pend_uncorr_ff <= 1'b0;
    type_ff <= 2'h0;
    pos_ff <= 8'h00;
    cap_addr_ff <= 27'h0;
    cap_way_ff <= 2'h0;
    cap_ram_ff <= 1'b0;
  end
  else if (capture)
  begin
    // overwrite replaces the source, so only one source flag stands
    dma_flag_ff <= sel_data ? dside_dma_in : pside_dma_in;
    prog_flag_ff <= ~sel_data & ~pside_dma_in;
    data_flag_ff <= sel_data & ~dside_dma_in;
    pend_uncorr_ff <= sel_unc;
    type_ff <= sel_data ? dside_type_in : pside_type_in;
    // data level-one errors of every type carry no usable position
    pos_ff <= (sel_data & dside_l1_in) ? 8'h00 : (sel_data ? dside_pos_in : pside_pos_in);
    cap_addr_ff <= sel_data ? dside_addr_in[31:5] : pside_addr_in[31:5];
    cap_ram_ff <= sel_data ? dside_ram_in : pside_ram_in;
    if (sel_data ? dside_ram_in : pside_ram_in)
      cap_way_ff <= 2'h0;
    else
      cap_way_ff <= sel_data ? dside_way_in : pside_way_in;
  end
  else
  begin
    dma_flag_ff <= dma_left;
    prog_flag_ff <= prog_left;
    data_flag_ff <= data_left;
    if (any_clr)
    begin
      // address capture and detail cleared with any source clear
      cap_addr_ff <= 27'h0;
      cap_way_ff <= 2'h0;
      cap_ram_ff <= 1'b0;
      type_ff <= 2'h0;
      pos_ff <= 8'h00;
      if (!(dma_left | prog_left | data_left))
        pend_uncorr_ff <= 1'b0;
    end
  end
end

////////////////////////////////////////////////////////////////////////////////
// exceptions: one-cycle pulse on each accepted capture
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    corrected_error_exception_out <= 1'b0;
    uncorrectable_error_exception_out <= 1'b0;
  end
  else
  begin
    corrected_error_exception_out <= capture & ~sel_unc;
    uncorrectable_error_exception_out <= capture & sel_unc;
  end
end

////////////////////////////////////////////////////////////////////////////////
// parity generation qualifier for writes, emulation writes included
// pause stops generation as well as checking; disabled pages never touch parity
wire gen_ok = wr_req_in & checking & page_on(wr_addr_in, pen0_ff, pen1_ff);
always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
  begin
    par_gen_out <= 1'b0;
    par_valid_out <= 1'b0;
  end
  else
  begin
    par_gen_out <= gen_ok;
    par_valid_out <= gen_ok & wr_full_in;
  end
end

////////////////////////////////////////////////////////////////////////////////
// read mux; data stands one cycle after the read strobe
always @*
begin
  nxt_rdata = 32'h0000_0000;
  if (reg_rd_in)
  begin
    case (reg_addr_in)
      `L2EDC_OFS_STATUS:
      begin
        nxt_rdata[`L2EDC_ST_POS_LO+7:`L2EDC_ST_POS_LO] = pos_ff;
        nxt_rdata[`L2EDC_ST_TYPE_LO+1:`L2EDC_ST_TYPE_LO] = type_ff;
        nxt_rdata[`L2EDC_ST_DMA] = dma_flag_ff;
        nxt_rdata[`L2EDC_ST_PROG] = prog_flag_ff;
        nxt_rdata[`L2EDC_ST_DATA] = data_flag_ff;
        nxt_rdata[`L2EDC_ST_PAUSE] = (state_ff == `L2EDC_STATE_PAUSE);
        nxt_rdata[`L2EDC_ST_DIS] = (state_ff == `L2EDC_STATE_DIS);
        nxt_rdata[`L2EDC_ST_EN] = (state_ff == `L2EDC_STATE_EN);
      end
      `L2EDC_OFS_COMMAND: nxt_rdata = 32'h0000_0000;
      `L2EDC_OFS_ADDRCAP: nxt_rdata = {cap_addr_ff, cap_way_ff, 2'h0, cap_ram_ff};
      `L2EDC_OFS_PEN0: nxt_rdata = pen0_ff;
      `L2EDC_OFS_PEN1: nxt_rdata = pen1_ff;
      `L2EDC_OFS_CORR_CNT: nxt_rdata = {24'h000000, corr_cnt_ff};
      `L2EDC_OFS_UNCORR_CNT: nxt_rdata = {24'h000000, uncorr_cnt_ff};
      default: nxt_rdata = 32'h0000_0000; // unmapped reads zero
    endcase
  end
end

always @(posedge ref_clk_in or negedge rst_n_in)
begin
  if (!rst_n_in)
    reg_rdata_out <= 32'h0000_0000;
  else
    reg_rdata_out <= nxt_rdata;
end

endmodule // l2edc_ctrl

//--- include/l2edc_defs.vh
`ifndef L2EDC_DEFS_VH
`define L2EDC_DEFS_VH
// register offsets (byte addresses, one 32-bit word each)
`define L2EDC_OFS_STATUS 8'h04
`define L2EDC_OFS_COMMAND 8'h08
`define L2EDC_OFS_ADDRCAP 8'h0c
`define L2EDC_OFS_PEN0 8'h10
`define L2EDC_OFS_PEN1 8'h14
`define L2EDC_OFS_CORR_CNT 8'h18
`define L2EDC_OFS_UNCORR_CNT 8'h1c
// command bit positions
`define L2EDC_CMD_DMA_CLR 6
`define L2EDC_CMD_PROG_CLR 5
`define L2EDC_CMD_DATA_CLR 4
`define L2EDC_CMD_PAUSE 3
`define L2EDC_CMD_DIS 2
`define L2EDC_CMD_EN 0
// status field positions
`define L2EDC_ST_DMA 6
`define L2EDC_ST_PROG 5
`define L2EDC_ST_DATA 4
`define L2EDC_ST_PAUSE 3
`define L2EDC_ST_DIS 2
`define L2EDC_ST_EN 0
`define L2EDC_ST_TYPE_LO 8
`define L2EDC_ST_POS_LO 16
// error type codes
`define L2EDC_TYPE_SINGLE 2'h0
`define L2EDC_TYPE_DOUBLE 2'h1
`define L2EDC_TYPE_PARITY 2'h3
// logic state codes
`define L2EDC_STATE_DIS 2'h0
`define L2EDC_STATE_EN 2'h1
`define L2EDC_STATE_PAUSE 2'h2
// reset values
`define L2EDC_PEN_RESET 32'h0000_0000
`define L2EDC_CNT_RESET 8'h00
`endif

//--- tb/l2edc_props.sv
`timescale 1ns/10ps
`include "l2edc_defs.vh"
////////////////////////////////////////
// port-level checks of the edc control block
module l2edc_props
(
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire [7:0] reg_addr_in,
  input wire [31:0] reg_wdata_in,
  input wire reg_wr_in,
  input wire reg_rd_in,
  input wire [31:0] reg_rdata_out,
  input wire dside_err_in,
  input wire dside_uncorr_in,
  input wire dside_emu_in,
  input wire pside_err_in,
  input wire pside_uncorr_in,
  input wire pside_emu_in,
  input wire corrected_error_exception_out,
  input wire uncorrectable_error_exception_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  wire cmd_wr = reg_wr_in && reg_addr_in == `L2EDC_OFS_COMMAND; // command write
  wire clr_wr = cmd_wr && |reg_wdata_in[6:4]; // any error clear bit
  wire ce = corrected_error_exception_out;
  wire ue = uncorrectable_error_exception_out;
  wire d_ok = dside_err_in && !dside_emu_in; // emulation reads never count
  wire p_ok = pside_err_in && !pside_emu_in;
  ////////////////////////////////////////
  a_cmd_reads_zero: assert property (reg_rd_in && reg_addr_in == `L2EDC_OFS_COMMAND |=> reg_rdata_out == 32'h0)
    else $error("command read not zero");
  a_rdata_idle_zero: assert property (!reg_rd_in |=> reg_rdata_out == 32'h0)
    else $error("read data outside read slot");
  a_exc_exclusive: assert property (!(ce && ue))
    else $error("both exceptions at once");
  a_emu_quiet: assert property ((dside_err_in || pside_err_in) && !d_ok && !p_ok |=> !ce && !ue)
    else $error("emulation read raised exception");
  a_corr_cause: assert property (ce |-> $past(d_ok || p_ok))
    else $error("corrected pulse without error");
  a_uncorr_cause: assert property (ue |-> $past(d_ok && dside_uncorr_in || p_ok && pside_uncorr_in))
    else $error("uncorrectable pulse without cause");
  // a second corrected pulse needs a clear first
  a_one_outstanding: assert property ((ce && !clr_wr) ##1 !clr_wr [*3] |=> !ce)
    else $error("second exception while pending");
  a_off_quiet: assert property (cmd_wr && (reg_wdata_in[2] || reg_wdata_in[3] && reg_wdata_in[0])
    ##1 !reg_wr_in [*2] |=> !ce && !ue)
    else $error("exception while disabled");
  cover property (ce);
  cover property (ue);
  cover property (clr_wr);
endmodule // l2edc_props

bind l2edc_ctrl l2edc_props u_props (.ref_clk_in, .rst_n_in, .reg_addr_in, .reg_wdata_in, .reg_wr_in,
  .reg_rd_in, .reg_rdata_out, .dside_err_in, .dside_uncorr_in, .dside_emu_in, .pside_err_in,
  .pside_uncorr_in, .pside_emu_in, .corrected_error_exception_out, .uncorrectable_error_exception_out);

//--- tb/l2edc_err_src.sv
`timescale 1ns/10ps
////////////////////////////////////////
// far-side ports: {err,uncorr,emu,dma,ram,way,type,pos,addr}
module l2edc_err_src
(
  input wire ref_clk_in,
  input wire rst_n_in,
  input wire [48:0] dreq_in, // data side request
  input wire [48:0] preq_in, // program side request
  output reg [48:0] dside_out,
  output reg [48:0] pside_out
);
  // one-cycle report; idle fields invert so stale values never match
  always @(posedge ref_clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      dside_out <= 49'h0;
      pside_out <= 49'h0;
    end
    else
    begin
      dside_out <= dreq_in[48] ? dreq_in : {1'b0, ~dside_out[47:0]};
      pside_out <= preq_in[48] ? preq_in : {1'b0, ~pside_out[47:0]};
    end
  end
endmodule // l2edc_err_src

//--- tb/l2edc_ctrl_bench.sv
`timescale 1ns/10ps
`include "l2edc_defs.vh"
module l2edc_ctrl_bench;
  reg clk = 1'b0; // 40 mhz
  reg rst_n = 1'b0;
  reg [7:0] ra = 8'h0;
  reg [31:0] rw = 32'h0;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [48:0] dq = 49'h0; // partner requests
  reg [48:0] pq = 49'h0;
  reg wq = 1'b0; // parity write path
  reg [31:0] wa = 32'h0;
  reg wf = 1'b0;
  reg l1 = 1'b0; // data level-one source
  wire [31:0] rdat;
  wire [48:0] ds;
  wire [48:0] ps;
  wire pg, pv, ce, ue;
  reg [31:0] v;
  reg [71:0] rows [0:5]; // addr, wdata, readback
  integer err_total = 0;
  integer n_tests = 0;
  integer i;
  localparam [31:0] A = 32'h0000_1240; // page 0
  localparam [31:0] B = 32'h0000_1300; // page 0
  localparam [31:0] F = 32'hffff_ffff;
  ////////////////////////////////////////
  l2edc_ctrl dut (.ref_clk_in(clk), .rst_n_in(rst_n), .reg_addr_in(ra), .reg_wdata_in(rw), .reg_wr_in(wr),
    .reg_rd_in(rd), .reg_rdata_out(rdat), .dside_err_in(ds[48]), .dside_uncorr_in(ds[47]),
    .dside_emu_in(ds[46]), .dside_l1_in(l1), .dside_dma_in(ds[45]), .dside_addr_in(ds[31:0]),
    .dside_way_in(ds[43:42]), .dside_ram_in(ds[44]), .dside_type_in(ds[41:40]), .dside_pos_in(ds[39:32]),
    .pside_err_in(ps[48]), .pside_uncorr_in(ps[47]), .pside_emu_in(ps[46]), .pside_dma_in(ps[45]),
    .pside_addr_in(ps[31:0]), .pside_way_in(ps[43:42]), .pside_ram_in(ps[44]), .pside_type_in(ps[41:40]),
    .pside_pos_in(ps[39:32]), .wr_req_in(wq), .wr_addr_in(wa), .wr_full_in(wf), .par_gen_out(pg),
    .par_valid_out(pv), .corrected_error_exception_out(ce), .uncorrectable_error_exception_out(ue));
  l2edc_err_src u_src (.ref_clk_in(clk), .rst_n_in(rst_n), .dreq_in(dq), .preq_in(pq), .dside_out(ds),
    .pside_out(ps));
  ////////////////////////////////////////
  task chk(input [31:0] s, input [31:0] e);
  begin
    n_tests = n_tests + 1;
    if (s !== e)
    begin
      err_total = err_total + 1;
      $display("Error t=%0t seen=%h exp=%h", $time, s, e);
    end
  end
  endtask
  task wreg(input [7:0] a, input [31:0] d);
  begin
    @(posedge clk) {ra, rw, wr} <= {a, d, 1'b1};
    @(posedge clk) wr <= 1'b0;
  end
  endtask
  // read, then compare masked data in the slot after the strobe
  task rc(input [7:0] a, input [31:0] m, input [31:0] e);
  begin
    @(posedge clk) {ra, rd} <= {a, 1'b1};
    @(posedge clk) rd <= 1'b0;
    #1 chk(rdat & m, e);
  end
  endtask
  // one error report per side, exceptions seen two edges later
  task err(input [48:0] d, input [48:0] p, input [1:0] e);
  begin
    @(posedge clk) {dq, pq} <= {d, p};
    @(posedge clk) {dq, pq} <= 98'h0;
    @(posedge clk) #1 chk({ce, ue}, e);
  end
  endtask
  task pw(input [31:0] a, input f, input [1:0] e);
  begin
    @(posedge clk) {wq, wa, wf} <= {1'b1, a, f};
    @(posedge clk) wq <= 1'b0;
    #1 chk({pg, pv}, e);
  end
  endtask
  function [48:0] q(input u, input em, input dm, input rm, input [1:0] w, input [31:0] a);
    q = {1'b1, u, em, dm, rm, w, `L2EDC_TYPE_SINGLE, 8'h07, a};
  endfunction
  task summarize;
  begin
    $display("errors=%0d tests=%0d", err_total, n_tests);
    if (err_total == 0 && n_tests > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  end
  endtask
  ////////////////////////////////////////
  initial forever #12.5 clk = ~clk;
  // hang guard, run needs about 140 cycles
  initial
  begin
    repeat (3000) @(posedge clk);
    err_total = err_total + 1;
    summarize;
  end
  initial
  begin
    rows[0] = {8'h10, 32'hffff_0001, 32'hffff_0001};
    rows[1] = {8'h14, 32'h0000_0002, 32'h0000_0002};
    rows[2] = {8'h08, 32'h0000_0001, 32'h0000_0000};
    rows[3] = {8'h0c, F, 32'h0000_0000};
    rows[4] = {8'h20, 32'h0000_0005, 32'h0000_0000};
    rows[5] = {8'h10, 32'h0000_0001, 32'h0000_0001};
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    rc(`L2EDC_OFS_STATUS, F, 32'h1);
    rc(`L2EDC_OFS_PEN0, F, `L2EDC_PEN_RESET);
    rc(`L2EDC_OFS_CORR_CNT, F, 32'h0);
    for (i = 0; i < 6; i = i + 1)
    begin
      wreg(rows[i][71:64], rows[i][63:32]);
      rc(rows[i][71:64], F, rows[i][31:0]);
    end
    // capture, hold while pending, uncorrectable overrides
    err(q(0, 0, 0, 0, 2'h2, A), 49'h0, 2'b10);
    rc(`L2EDC_OFS_STATUS, F, 32'h0007_0011);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0000_1250);
    err(q(0, 0, 0, 1, 2'h1, B), 49'h0, 2'b00);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0000_1250);
    rc(`L2EDC_OFS_CORR_CNT, F, 32'h2);
    err(49'h0, q(1, 0, 0, 1, 2'h3, B), 2'b01);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0000_1301);
    wreg(`L2EDC_OFS_COMMAND, 32'h70);
    rc(`L2EDC_OFS_STATUS, F, 32'h1);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0);
    // same-cycle collision, data side wins
    err(q(1, 0, 0, 0, 2'h1, A), q(1, 0, 0, 0, 2'h2, B), 2'b01);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0000_1248);
    rc(`L2EDC_OFS_STATUS, 32'h70, 32'h10);
    wreg(`L2EDC_OFS_COMMAND, 32'h10);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0);
    err(q(0, 0, 1, 0, 2'h0, A), 49'h0, 2'b10);
    rc(`L2EDC_OFS_STATUS, 32'h7f, 32'h41);
    wreg(`L2EDC_OFS_COMMAND, 32'h40);
    rc(`L2EDC_OFS_STATUS, 32'h7f, 32'h1);
    // region 1 page, then disabled page and emulation read
    err(49'h0, q(0, 0, 0, 0, 2'h0, 32'h0010_8000), 2'b10);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0010_8000);
    wreg(`L2EDC_OFS_COMMAND, 32'h20);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0);
    err(q(0, 0, 0, 0, 2'h0, 32'h0000_8000), 49'h0, 2'b00);
    pw(32'h0000_8000, 1'b1, 2'b00);
    err(q(1, 1, 0, 0, 2'h0, A), 49'h0, 2'b00);
    rc(`L2EDC_OFS_CORR_CNT, F, 32'h4);
    rc(`L2EDC_OFS_UNCORR_CNT, F, 32'h3);
    pw(A, 1'b1, 2'b11);
    pw(A, 1'b0, 2'b10);
    // conflicting state bits fall back to disabled
    wreg(`L2EDC_OFS_COMMAND, 32'h09);
    rc(`L2EDC_OFS_STATUS, 32'hf, 32'h4);
    err(q(0, 0, 0, 0, 2'h0, A), 49'h0, 2'b00);
    pw(A, 1'b1, 2'b00);
    wreg(`L2EDC_OFS_COMMAND, 32'h08);
    rc(`L2EDC_OFS_STATUS, 32'hf, 32'h8);
    err(q(0, 0, 0, 0, 2'h0, A), 49'h0, 2'b00);
    pw(A, 1'b1, 2'b00);
    wreg(`L2EDC_OFS_COMMAND, 32'h01);
    rc(`L2EDC_OFS_STATUS, 32'hf, 32'h1);
    rc(`L2EDC_OFS_CORR_CNT, F, 32'h4);
    // data level-one parity-bit error: no usable position
    @(posedge clk) l1 <= 1'b1;
    err(q(0, 0, 0, 0, 2'h0, A) | 49'h300_0000_0000, 49'h0, 2'b10);
    rc(`L2EDC_OFS_STATUS, F, 32'h0000_0311);
    // reset in mid-run restores state, pages, counters and capture
    @(posedge clk) {rst_n, l1} <= 2'b00;
    @(posedge clk) rst_n <= 1'b1;
    rc(`L2EDC_OFS_STATUS, F, 32'h1);
    rc(`L2EDC_OFS_PEN1, F, `L2EDC_PEN_RESET);
    rc(`L2EDC_OFS_CORR_CNT, F, 32'h0);
    rc(`L2EDC_OFS_ADDRCAP, F, 32'h0);
    summarize;
  end
endmodule // l2edc_ctrl_bench
